// ---- cpu_alu_branch_unit.sv ----
// Purpose: Executes arithmetic, logic, multiply, skip, branch and indirect jump ops.
// Assumes: Sequencer holds req_i stable while req_valid_i and req_ready_o are high.
// Notes:   Flags update at acceptance; the result strobe comes after the op's length.
`timescale 1ns/10ps

module cpu_alu_branch_unit (
	// Clock and reset.
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	// Instruction request.
	input  wire logic          req_valid_i,
	input  wire alu_pkg::req_t req_i,
	output logic               req_ready_o,
	// Result and flags.
	output alu_pkg::res_t      res_o,
	output logic               res_valid_o,
	output logic [7:0]         status_o,
	// APB slave.
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic [31:0]        prdata_o,
	output logic               pready_o,
	output logic               pslverr_o
);
	import alu_pkg::*;

	logic [7:0]  status_reg;
	logic [5:0]  jump_extension_reg;
	logic [2:0]  cnt;
	res_t        res;
	logic        res_valid;
	logic [31:0] prdata;
	res_t        next_res;
	logic [7:0]  next_flags;
	logic [2:0]  next_cyc;

	////////////////////////////////////////////////////////////////////////////////
	// Operand decode.

	// Short names for the operands of the request in flight.
	wire op_t        op = req_i.op;
	wire [7:0]       a  = req_i.rd;
	wire [7:0]       b  = req_i.rr;
	wire [21:0]      pc = req_i.pc;
	wire             acc = req_valid_i && req_ready_o;

	// Op classes.
	wire is_add = (op == op_add) || (op == op_add_carry);
	wire is_sub = (op == op_sub) || (op == op_sub_carry_in) ||
	              (op == op_compare) || (op == op_compare_carry);
	wire use_cin = (op == op_add_carry) || (op == op_sub_carry_in) ||
	               (op == op_compare_carry);
	wire z_chain = (op == op_sub_carry_in) || (op == op_compare_carry);
	wire is_logic = (op == op_and) || (op == op_or) || (op == op_xor_reg) ||
	                (op == op_set_bits_imm) || (op == op_clear_bits_imm) ||
	                (op == op_test_zero_minus);
	wire is_incdec = (op == op_inc) || (op == op_dec);
	wire is_word = (op == op_add_imm_word) || (op == op_sub_imm_word);
	wire is_frac = (op == op_frac_mul_unsigned) || (op == op_frac_mul_signed) ||
	               (op == op_frac_mul_mixed);
	wire is_mul = is_frac || (op == op_mul_unsigned) || (op == op_mul_signed) ||
	              (op == op_mul_signed_unsigned);

	////////////////////////////////////////////////////////////////////////////////
	// Byte arithmetic.

	wire       cin  = use_cin & status_reg[F_C];
	wire [8:0] add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	wire [8:0] sub9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
	wire [4:0] add5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	wire [4:0] sub5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
	wire [7:0] ar   = is_sub ? sub9[7:0] : add9[7:0];
	wire       ac   = is_sub ? sub9[8] : add9[8];
	wire       ah   = is_sub ? sub5[4] : add5[4];

	// Overflow: operand signs agree (add) or differ (subtract) and the result flips.
	wire       av = (is_sub ? (a[7] != b[7]) : (a[7] == b[7])) && (ar[7] != a[7]);

	wire       az = (ar == 8'h00) && (!z_chain || status_reg[F_Z]);
	wire [7:0] arith_f = {status_reg[F_I], status_reg[F_T], ah, av ^ ar[7], av, ar[7], az,
	                      ac};

	////////////////////////////////////////////////////////////////////////////////
	// Logic, bit set and clear, test.

	wire [7:0] lr_and = a & b;
	wire [7:0] lr_or  = a | b;
	wire [7:0] lr_xor = a ^ b;

	wire [7:0] lr_clr = a & ~b;

	wire [7:0] lr_tst = a & a;
	wire [7:0] lr = (op == op_and) ? lr_and :
	                (op == op_or || op == op_set_bits_imm) ? lr_or :
	                (op == op_xor_reg) ? lr_xor :
	                (op == op_clear_bits_imm) ? lr_clr : lr_tst;

	// Logic results clear V, so S simply follows N.
	wire [7:0] logic_f = {status_reg[7:5], lr[7], 1'b0, lr[7], lr == 8'h00, status_reg[F_C]};

	////////////////////////////////////////////////////////////////////////////////
	// Increment and decrement.

	wire [7:0] ir = (op == op_inc) ? a + 8'h01 : a - 8'h01;
	wire       iv = (op == op_inc) ? (ir == 8'h80) : (ir == 8'h7F);
	wire [7:0] incdec_f = {status_reg[7:5], ir[7] ^ iv, iv, ir[7], ir == 8'h00,
	                       status_reg[F_C]};

	////////////////////////////////////////////////////////////////////////////////
	// Word add and subtract of a six-bit constant.

	wire [15:0] w_add = req_i.word + {10'h000, b[5:0]};

	wire [15:0] w_sub = req_i.word - {10'h000, b[5:0]};
	wire [15:0] wr = (op == op_add_imm_word) ? w_add : w_sub;
	wire        wv = (op == op_add_imm_word) ? (!req_i.word[15] && wr[15]) :
	                 (req_i.word[15] && !wr[15]);
	wire        wc = (op == op_add_imm_word) ? (!wr[15] && req_i.word[15]) :
	                 (wr[15] && !req_i.word[15]);

	// Half-carry is left alone for word ops.
	wire [7:0] word_f = {status_reg[7:5], wr[15] ^ wv, wv, wr[15], wr == 16'h0000, wc};

	////////////////////////////////////////////////////////////////////////////////
	// Multiply.

	wire        [15:0] p_uu = {8'h00, a} * {8'h00, b};
	wire signed [15:0] p_ss = $signed({{8{a[7]}}, a}) * $signed({{8{b[7]}}, b});
	wire signed [15:0] p_su = $signed({{8{a[7]}}, a}) * $signed({8'h00, b});
	wire [15:0] prod = (op == op_mul_unsigned || op == op_frac_mul_unsigned) ? p_uu :
	                   (op == op_mul_signed || op == op_frac_mul_signed) ? p_ss : p_su;

	wire [15:0] mr = is_frac ? {prod[14:0], 1'b0} : prod;

	// Carry takes bit 15 of the unshifted product in both forms.
	wire [7:0] mul_f = {status_reg[7:2], mr == 16'h0000, prod[15]};

	////////////////////////////////////////////////////////////////////////////////
	// Skips, branches and indirect targets.

	wire reg_bit = a[req_i.bsel];

	wire io_bit = req_i.io_reg[req_i.bsel];

	wire skip = (op == op_compare_skip_equal) ? (a == b) :
	            (op == op_skip_reg_bit_clear) ? !reg_bit :
	            (op == op_skip_reg_bit_set) ? reg_bit :
	            (op == op_skip_io_bit_clear) ? !io_bit : io_bit;
	wire [21:0] skip_pc = pc + (req_i.two_word ? 22'h000003 : 22'h000002);

	wire sflag = status_reg[req_i.bsel];

	wire nxv = status_reg[F_N] ^ status_reg[F_V];

	wire take = (op == op_branch_flag_set) ? sflag :
	            (op == op_branch_flag_clear) ? !sflag :
	            (op == op_branch_ge_signed) ? !nxv : nxv;
	wire [21:0] br_pc = pc + {{10{req_i.k[11]}}, req_i.k} + 22'h000001;

	wire [21:0] ij_pc = {6'h00, req_i.z};

	wire [21:0] eij_pc = {jump_extension_reg, req_i.z};

	////////////////////////////////////////////////////////////////////////////////
	// Result assembly per op.

	// Unused fields stay zero so the sequencer sees clean strobes.
	always_comb begin
		next_res = '0;
		next_flags = status_reg;
		next_cyc = CYC_1;
		case (op)
			op_add, op_add_carry, op_sub, op_sub_carry_in: begin
				next_res.wr_byte = 1'b1;
				next_res.data = {8'h00, ar};
				next_flags = arith_f;
			end
			op_compare, op_compare_carry: begin
				next_flags = arith_f;
			end
			op_and, op_or, op_xor_reg, op_set_bits_imm, op_clear_bits_imm: begin
				next_res.wr_byte = 1'b1;
				next_res.data = {8'h00, lr};
				next_flags = logic_f;
			end
			op_test_zero_minus: begin
				next_flags = logic_f;
			end
			op_inc, op_dec: begin
				next_res.wr_byte = 1'b1;
				next_res.data = {8'h00, ir};
				next_flags = incdec_f;
			end
			op_add_imm_word, op_sub_imm_word: begin
				next_res.wr_pair = 1'b1;
				next_res.data = wr;
				next_flags = word_f;
				next_cyc = CYC_2;
			end
			op_mul_unsigned, op_mul_signed, op_mul_signed_unsigned,
			op_frac_mul_unsigned, op_frac_mul_signed, op_frac_mul_mixed: begin
				next_res.wr_r1r0 = 1'b1;
				next_res.data = mr;
				next_flags = mul_f;
				next_cyc = CYC_2;
			end
			op_indirect_jump: begin
				next_res.pc_load = 1'b1;
				next_res.pc_next = ij_pc;
				next_cyc = CYC_2;
			end
			op_ext_indirect_jump: begin
				next_res.pc_load = 1'b1;
				next_res.pc_next = eij_pc;
				next_cyc = CYC_2;
			end
			op_ext_indirect_call: begin
				next_res.pc_load = 1'b1;
				next_res.pc_next = eij_pc;
				next_res.push = 1'b1;
				next_res.ret_addr = pc + 22'h000001;
				next_cyc = CYC_4;
			end
			op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
			op_skip_io_bit_clear, op_skip_io_bit_set: begin
				next_res.pc_load = skip;
				next_res.pc_next = skip ? skip_pc : pc + 22'h000001;
				next_cyc = !skip ? CYC_1 : (req_i.two_word ? CYC_3 : CYC_2);
			end
			op_branch_flag_set, op_branch_flag_clear, op_branch_ge_signed,
			op_branch_lt_signed: begin
				next_res.pc_load = take;
				next_res.pc_next = take ? br_pc : pc + 22'h000001;
				next_cyc = take ? CYC_2 : CYC_1;
			end
			default: begin
				next_cyc = CYC_1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Execution sequencing.

	// A new op is taken only when the previous one has finished its cycles.
	assign req_ready_o = (cnt == 3'h0);
	assign res_o = res;
	assign res_valid_o = res_valid;
	assign status_o = status_reg;

	// Result is captured at acceptance; the strobe fires on the op's last cycle.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 3'h0;
			res <= '0;
			res_valid <= 1'b0;
		end else if (acc) begin
			cnt <= next_cyc - CYC_1;
			res <= next_res;
			res_valid <= (next_cyc == CYC_1);
		end else begin
			cnt <= (cnt == 3'h0) ? 3'h0 : cnt - 3'h1;
			res_valid <= (cnt == 3'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave.

	// Zero wait states: every access ends in its first access cycle.
	wire apb_setup  = psel_i && !penable_i;
	wire apb_access = psel_i && penable_i;
	wire hit_status = (paddr_i == ADDR_STATUS);
	wire hit_jext   = (paddr_i == ADDR_JEXT);
	wire hit_result = (paddr_i == ADDR_RESULT);
	wire apb_hit    = hit_status || hit_jext || hit_result;
	wire wr_status  = apb_access && pwrite_i && hit_status;
	wire wr_jext    = apb_access && pwrite_i && hit_jext;
	wire [31:0] rd_mux = hit_status ? {24'h000000, status_reg} :
	                     hit_jext ? {26'h0000000, jump_extension_reg} :
	                     hit_result ? {16'h0000, res.data} : 32'h00000000;

	assign pready_o  = 1'b1;
	assign pslverr_o = apb_access && !apb_hit;
	assign prdata_o  = prdata;

	// Read data is latched in the setup cycle so it comes from a flip-flop.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata <= 32'h00000000;
		end else if (apb_setup && !pwrite_i) begin
			prdata <= rd_mux;
		end
	end

	// A flag update by an op wins over a software write in the same cycle.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			status_reg <= STATUS_RST;
		end else if (acc) begin
			status_reg <= next_flags;
		end else if (wr_status) begin
			status_reg <= pwdata_i[7:0];
		end
	end

	// Only the six bits that reach PC[21:16] are stored.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			jump_extension_reg <= JEXT_RST;
		end else if (wr_jext) begin
			jump_extension_reg <= pwdata_i[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_add_result: assert property (
		acc && op == op_add |=> res_valid_o &&
		res_o.data[7:0] == 8'($past(req_i.rd) + $past(req_i.rr)))
		else $error("byte add result wrong");

	a_word_two_cyc: assert property (
		acc && op == op_add_imm_word |=> !res_valid_o ##1 res_valid_o && res_o.wr_pair)
		else $error("word add not two cycles");

	a_subw_result: assert property (
		acc && op == op_sub_imm_word |-> ##2 res_valid_o &&
		res_o.data == 16'($past(req_i.word, 2) - {10'h000, $past(req_i.rr[5:0], 2)}))
		else $error("word subtract result wrong");

	a_logic_vclr: assert property (
		acc && (op == op_and || op == op_or || op == op_xor_reg) |=>
		!status_reg[F_V] && res_o.wr_byte && status_reg[F_C] == $past(status_reg[F_C]))
		else $error("logic flags wrong");

	a_clear_bits: assert property (
		acc && op == op_clear_bits_imm |=>
		res_o.data[7:0] == ($past(req_i.rd) & ~$past(req_i.rr)))
		else $error("bit clear result wrong");

	a_test_nowr: assert property (
		acc && op == op_test_zero_minus |=> !res_o.wr_byte &&
		status_reg[F_Z] == ($past(req_i.rd) == 8'h00))
		else $error("test wrote or set wrong Z");

	a_mul_product: assert property (
		acc && op == op_mul_unsigned |=> !res_valid_o ##1 res_valid_o &&
		res_o.data == {8'h00, $past(req_i.rd, 2)} * {8'h00, $past(req_i.rr, 2)})
		else $error("unsigned product wrong");

	a_frac_shift: assert property (
		acc && op == op_frac_mul_unsigned |-> ##2 res_valid_o && res_o.data[0] == 1'b0)
		else $error("fractional product not shifted");

	a_jump_upper: assert property (
		acc && op == op_indirect_jump |-> ##2 res_valid_o &&
		res_o.pc_next == {6'h00, $past(req_i.z, 2)})
		else $error("indirect jump target wrong");

	a_call_four: assert property (
		acc && op == op_ext_indirect_call |=> !res_valid_o [*3] ##1 res_valid_o && res_o.push)
		else $error("extended call not four cycles");

	a_cmp_nowr: assert property (
		acc && (op == op_compare || op == op_compare_carry) |=>
		!res_o.wr_byte && !res_o.wr_pair && !res_o.wr_r1r0)
		else $error("compare wrote a register");

	a_inc_carry: assert property (
		acc && is_incdec |=> status_reg[F_C] == $past(status_reg[F_C]))
		else $error("inc or dec changed carry");

	c_branch_taken: cover property (acc && is_logic == 1'b0 && take &&
		op == op_branch_flag_set ##2 res_valid_o && res_o.pc_load);
	c_skip_long: cover property (acc && skip && req_i.two_word &&
		op == op_compare_skip_equal ##3 res_valid_o);
	c_frac_signed: cover property (acc && op == op_frac_mul_signed ##2 res_valid_o);

endmodule

// ---- alu_pkg.sv ----
// Purpose: Shared types and constants for the core's ALU and program-flow unit.
// Assumes: Flags sit in the order I T H S V N Z C, bit 7 down to bit 0.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
//
// Contract
// - Byte add/subtract, optional carry-in, writes Rd; updates Z C N V S H; 1 cycle.
// - Word add of a constant updates Z C N V S, keeps H; 2 cycles.
// - Word subtract of a constant writes the pair, updates Z C N V S; 2 cycles.
// - AND, OR, XOR write Rd and update only Z N V S; 1 cycle.
// - Set-bits ORs the constant, clear-bits ANDs its inverse; Z N V S; 1 cycle.
// - Test ANDs a register with itself, no write, updates Z N V S; 1 cycle.
// - Multiplies give 16-bit UU, SS or SU product into R1:R0; Z C; 2 cycles.
// - Fractional multiplies give the same product shifted left once; Z C; 2 cycles.
// - Indirect jump loads PC[15:0] from Z, PC[21:16] zero; 2 cycles; no flags.
// - Extended indirect jump takes PC[21:16] from the jump extension register; 2 cycles.
// - Extended indirect call uses Z and the extension register; 4 cycles.
// - Compare-skip-equal skips when registers match; 1, 2 or 3 cycles; no flags.
// - Register-bit skips test a selected bit, clear or set variant; 1, 2 or 3 cycles.
// - I/O-bit skips test a selected I/O bit, clear or set; no flag change.
// - Flag branches go to PC+k+1 on the selected flag set or clear; 1 or 2 cycles.
// - Signed branches test N XOR V, zero for greater-equal, one for less-than.
// - Unsigned branches test carry; equal tests Z, minus/plus test N.
// - Dedicated branches test H, T, V and I flags, set or cleared.

package alu_pkg;

	// Status flag positions.
	localparam int F_C = 0;
	localparam int F_Z = 1;
	localparam int F_N = 2;
	localparam int F_V = 3;
	localparam int F_S = 4;
	localparam int F_H = 5;
	localparam int F_T = 6;
	localparam int F_I = 7;

	// Execution lengths in core clock cycles.
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;

	// APB register byte offsets and reset values.
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_JEXT   = 12'h004;
	localparam logic [11:0] ADDR_RESULT = 12'h008;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [5:0]  JEXT_RST    = 6'h00;

	typedef enum logic [5:0] {
		op_add, op_add_carry, op_sub, op_sub_carry_in, op_and, op_or, op_xor_reg,
		op_set_bits_imm, op_clear_bits_imm, op_test_zero_minus, op_inc, op_dec,
		op_compare, op_compare_carry, op_add_imm_word, op_sub_imm_word,
		op_mul_unsigned, op_mul_signed, op_mul_signed_unsigned,
		op_frac_mul_unsigned, op_frac_mul_signed, op_frac_mul_mixed,
		op_indirect_jump, op_ext_indirect_jump, op_ext_indirect_call,
		op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
		op_skip_io_bit_clear, op_skip_io_bit_set, op_branch_flag_set,
		op_branch_flag_clear, op_branch_ge_signed, op_branch_lt_signed
	} op_t;

	// One instruction as handed over by the sequencer.
	typedef struct packed {
		op_t         op;
		logic [7:0]  rd;
		logic [7:0]  rr;
		logic [15:0] word;
		logic [15:0] z;
		logic [21:0] pc;
		logic [11:0] k;
		logic [2:0]  bsel;
		logic [7:0]  io_reg;
		logic        two_word;
	} req_t;

	// Write-back and program-flow result.
	typedef struct packed {
		logic        wr_byte;
		logic        wr_pair;
		logic        wr_r1r0;
		logic [15:0] data;
		logic        pc_load;
		logic [21:0] pc_next;
		logic        push;
		logic [21:0] ret_addr;
	} res_t;

endpackage

// ---- seq_model.sv ----
// Purpose: Sequencer stand-in that hands instructions to the execution unit.
// Assumes: A request is taken at a rising edge where valid and ready are both high.
// Notes:   After a take the request lines show the inverse of the last value.
`timescale 1ns/10ps

module seq_model
	import alu_pkg::*;
(
	// Clock.
	input  wire logic    mclk_i,
	// Handshake with the unit.
	input  wire logic    req_ready_i,
	input  wire logic    res_valid_i,
	output logic         req_valid_o,
	output alu_pkg::req_t req_o
);
	import alu_pkg::*;

	// Idle at time zero so the unit sees no request during reset.
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end

	// Present one request, wait for the take, then count cycles to completion.
	// The released lines are inverted so stale operands can never look valid.
	task automatic issue(input req_t r, output int n);
		@(posedge mclk_i);
		req_valid_o <= 1'b1;
		req_o <= r;
		do
			@(posedge mclk_i);
		while (req_ready_i !== 1'b1);
		req_valid_o <= 1'b0;
		req_o <= ~r;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (res_valid_i !== 1'b1);
	endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the ALU and program-flow unit.
// Assumes: Flags update at the take edge; res_o is settled at the completion pulse.
// Notes:   Expected values are worked out by hand from the flag equations.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module testbench;
	import alu_pkg::*;

	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req_valid;
	logic        req_ready;
	logic        res_valid;
	req_t        req;
	res_t        res;
	logic [7:0]  status;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          bad_count = 0;
	int          n_checks = 0;

	// The clock runs at 20 MHz.
	always #25 mclk_i = ~mclk_i;

	cpu_alu_branch_unit DUT (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(req_ready), .res_o(res), .res_valid_o(res_valid),
		.status_o(status), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr));

	seq_model seq (.mclk_i(mclk_i), .req_ready_i(req_ready), .res_valid_i(res_valid),
		.req_valid_o(req_valid), .req_o(req));

	////////////////////////////////////////////////////////////////////////////////
	// One APB transfer; read data and error are taken at the pready edge only.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do
			@(posedge mclk_i);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic req_t mk(op_t o, logic [7:0] d, logic [7:0] s);
		req_t r;
		r = '0;
		r.op = o;
		r.rd = d;
		r.rr = s;
		return r;
	endfunction

	// Run one op and judge its length and the flags it leaves.
	task automatic ex(input req_t r, input int len, input logic [7:0] st);
		int n;
		seq.issue(r, n);
		`CHK("length", len, n)
		`CHK("status", st, status)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and register access kinds.
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		`CHK("ready", 1'b1, req_ready)
		apb(1'b0, ADDR_STATUS, 32'h0, q, e);
		`CHK("status rd", {24'h0, STATUS_RST}, q)
		apb(1'b0, ADDR_JEXT, 32'h0, q, e);
		`CHK("jext rd", {26'h0, JEXT_RST}, q)
		apb(1'b0, 12'h00C, 32'h0, q, e);
		`CHK("unmapped err", 1'b1, e)
	endtask

	task automatic t_arith();
		req_t r;
		ex(mk(op_add, 8'h7F, 8'h01), 1, 8'h2C);
		`CHK("add data", 8'h80, res.data[7:0])
		ex(mk(op_sub_carry_in, 8'h05, 8'h05), 1, 8'h00);
		`CHK("sbc data", 9'h100, {res.wr_byte, res.data[7:0]})
		ex(mk(op_sub, 8'h00, 8'h01), 1, 8'h35);
		`CHK("sub data", 9'h1FF, {res.wr_byte, res.data[7:0]})
		ex(mk(op_add_carry, 8'hFF, 8'h00), 1, 8'h23);
		`CHK("adc data", 9'h100, {res.wr_byte, res.data[7:0]})
		r = mk(op_add_imm_word, 8'hFF, 8'h01);
		r.word = 16'hFFFF;
		ex(r, 2, 8'h23);
		`CHK("adw data", 17'h10000, {res.wr_pair, res.data})
		r = mk(op_sub_imm_word, 8'h00, 8'h01);
		r.word = 16'h0000;
		ex(r, 2, 8'h35);
		`CHK("sbw data", 17'h1FFFF, {res.wr_pair, res.data})
	endtask

	// logic, test, compare, inc and dec.
	task automatic t_logic();
		ex(mk(op_and, 8'hF0, 8'h0F), 1, 8'h23);
		`CHK("and data", 9'h100, {res.wr_byte, res.data[7:0]})
		ex(mk(op_xor_reg, 8'hAA, 8'h55), 1, 8'h35);
		`CHK("xor data", 8'hFF, res.data[7:0])
		ex(mk(op_clear_bits_imm, 8'hFF, 8'h0F), 1, 8'h35);
		`CHK("clr data", 8'hF0, res.data[7:0])
		ex(mk(op_set_bits_imm, 8'h00, 8'h81), 1, 8'h35);
		`CHK("set data", 8'h81, res.data[7:0])
		ex(mk(op_or, 8'h00, 8'h00), 1, 8'h23);
		`CHK("or data", 9'h100, {res.wr_byte, res.data[7:0]})
		ex(mk(op_test_zero_minus, 8'h00, 8'h00), 1, 8'h23);
		ex(mk(op_inc, 8'h7F, 8'h00), 1, 8'h2D);
		ex(mk(op_dec, 8'h80, 8'h00), 1, 8'h39);
		ex(mk(op_compare_carry, 8'h00, 8'h00), 1, 8'h35);
		`CHK("cpc write", 1'b0, res.wr_byte)
		ex(mk(op_compare, 8'h10, 8'h10), 1, 8'h02);
		`CHK("cmp write", 1'b0, res.wr_byte)
	endtask

	task automatic t_mul();
		op_t         o [6] = '{op_mul_signed, op_mul_unsigned, op_mul_signed_unsigned,
			op_frac_mul_unsigned, op_frac_mul_signed, op_frac_mul_mixed};
		logic [7:0]  a [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h40, 8'hC0};
		logic [7:0]  b [6] = '{8'hFF, 8'hFF, 8'h02, 8'h80, 8'h40, 8'h40};
		logic [15:0] p [6] = '{16'h0001, 16'hFE01, 16'hFFFE, 16'h8000, 16'h2000, 16'hE000};
		logic [7:0]  s [6] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
		for (int i = 0; i < 6; i++) begin
			ex(mk(o[i], a[i], b[i]), 2, s[i]);
			`CHK("product", {1'b1, p[i]}, {res.wr_r1r0, res.data})
		end
	endtask

	task automatic t_jump();
		req_t        r;
		logic [31:0] q;
		logic        e;
		r = mk(op_indirect_jump, 8'h00, 8'h00);
		r.z = 16'h1234;
		r.pc = 22'h3F0100;
		ex(r, 2, 8'h01);
		`CHK("indirect_jump pc", 23'h401234, {res.pc_load, res.pc_next})
		apb(1'b1, ADDR_JEXT, 32'hFFFFFFFF, q, e);
		apb(1'b0, ADDR_JEXT, 32'h0, q, e);
		`CHK("jext rd", 32'h0000003F, q)
		r.op = op_ext_indirect_jump;
		ex(r, 2, 8'h01);
		`CHK("ext_indirect_jump pc", 23'h7F1234, {res.pc_load, res.pc_next})
		r.op = op_ext_indirect_call;
		ex(r, 4, 8'h01);
		`CHK("call pc", 23'h7F1234, {res.pc_load, res.pc_next})
		`CHK("call ret", 23'h7F0101, {res.push, res.ret_addr})
	endtask

	task automatic t_flow();
		req_t        r;
		logic [31:0] q;
		logic        e;
		op_t         o [12] = '{op_compare_skip_equal, op_compare_skip_equal,
			op_skip_reg_bit_set, op_skip_reg_bit_clear, op_skip_io_bit_clear,
			op_skip_io_bit_set, op_branch_flag_set, op_branch_flag_clear,
			op_branch_flag_clear, op_branch_ge_signed, op_branch_lt_signed,
			op_branch_flag_set};
		logic [7:0]  b [12] = '{8'h05, 8'h06, 8'h08, 8'h08, 8'hF7, 8'hF7,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		int          sl [12] = '{0, 0, 3, 3, 3, 3, F_I, F_C, F_Z, 0, 0, F_H};
		int          ln [12] = '{3, 1, 2, 1, 2, 1, 2, 1, 2, 1, 2, 1};
		logic [21:0] pn [12] = '{22'h203, 22'h201, 22'h202, 22'h201, 22'h202, 22'h201,
			22'h1FF, 22'h201, 22'h1FF, 22'h201, 22'h1FF, 22'h201};
		apb(1'b1, ADDR_STATUS, 32'h000000C9, q, e);
		apb(1'b0, ADDR_STATUS, 32'h0, q, e);
		`CHK("status rd", 32'h000000C9, q)
		`CHK("status wr", 8'hC9, status)
		for (int i = 0; i < 12; i++) begin
			r = mk(o[i], (i < 2) ? 8'h05 : b[i], b[i]);
			r.io_reg = b[i];
			r.bsel = sl[i][2:0];
			r.two_word = (i == 0);
			r.pc = 22'h000200;
			r.k = 12'hFFE;
			ex(r, ln[i], 8'hC9);
			`CHK("flow pc", {ln[i] > 1, pn[i]}, {res.pc_load, res.pc_next})
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The single place where the run ends.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A hang costs a mismatch; the tests need well under 2000 cycles.
	initial begin
		#250000;
		bad_count++;
		end_of_test();
	end

	// Reset for ten cycles, then the scenarios in order.
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_arith();
		t_logic();
		t_mul();
		t_jump();
		t_flow();
		end_of_test();
	end
endmodule
